// >>> core/fcrm_consts.vh
// Constants for the feature control register mode logic.
`ifndef FCRM_CONSTS_VH
`define FCRM_CONSTS_VH

// ----------------------------------------------------------------------------
// Register word layout
// ----------------------------------------------------------------------------
// Fields are documented with bit 0 as the most significant bit of the word.
// The macros below give the matching Verilog (LSB = 0) position.
`define FCRM_WORD_W 32
`define FCRM_MSB_TO_LSB(n) (31 - (n))
`define FCRM_POS_PRESENCE 31
`define FCRM_POS_ONESHOT 26
`define FCRM_POS_ENABLE 25
`define FCRM_POS_AUTO 24
`define FCRM_POS_VALUE_LO 0
`define FCRM_VALUE_W 12

// ----------------------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------------------
`define FCRM_FEAT_BASE 8'h00
`define FCRM_FEAT_STRIDE 8'h04
`define FCRM_STAT_ADDR 8'h80

// ----------------------------------------------------------------------------
// Feature states, one-hot
// ----------------------------------------------------------------------------
`define FCRM_ST_OFF 4'h1
`define FCRM_ST_AUTO 4'h2
`define FCRM_ST_MANUAL 4'h4
`define FCRM_ST_ONESHOT 4'h8

// ----------------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------------
`define FCRM_RST_STATE 4'h1
`define FCRM_RST_VALUE 12'h000
`define FCRM_CLK_PERIOD_NS 20
`define FCRM_ADJ_PERIOD_NS 1000
`define FCRM_ADJ_CYCLES ((`FCRM_ADJ_PERIOD_NS + `FCRM_CLK_PERIOD_NS - 1) / `FCRM_CLK_PERIOD_NS)

`endif

// >>> core/fcrm_adjust.v
// Adjustment engine that walks a feature value one step toward a target.
`timescale 1ns/100ps

module fcrm_adjust #(
   parameter VW = 12,                        // Value field width.
   parameter [15:0] ADJ_CYCLES = 16'd50      // Clock cycles between two steps.
) (
   input wire mclk,                          // Device clock.
   input wire rst,                           // Synchronous reset, active high.
   input wire run,                           // Adjustment active (auto or one-shot).
   input wire [VW-1:0] cur,                  // Value currently in use.
   input wire [VW-1:0] target,               // Value the adjustment aims for.
   output reg upd_q,                         // One-cycle pulse: take upd_val_q.
   output reg [VW-1:0] upd_val_q,            // Next adjusted value.
   output reg settled_q                      // One-cycle pulse: value reached target.
);

   // ----------------------------------------------------------------------------
   // Step timer
   // ----------------------------------------------------------------------------
   reg [15:0] cnt_q;
   wire tick;

   assign tick = run && (cnt_q == 16'h0000);

   // The timer restarts whenever adjustment stops, so every run begins with a full interval.
   always @(posedge mclk) begin
      if (rst || !run || tick) begin
         cnt_q <= ADJ_CYCLES - 16'h0001;
      end else begin
         cnt_q <= cnt_q - 16'h0001;
      end
   end

   // ----------------------------------------------------------------------------
   // Step toward the target
   // ----------------------------------------------------------------------------
   // A unit step is slow but can never overshoot, so one-shot always ends.
   always @(posedge mclk) begin
      if (rst) begin
         upd_q <= 1'b0;
         upd_val_q <= {VW{1'b0}};
         settled_q <= 1'b0;
      end else begin
         upd_q <= 1'b0;
         settled_q <= 1'b0;
         if (tick) begin
            if (cur < target) begin
               upd_q <= 1'b1;
               upd_val_q <= cur + {{(VW-1){1'b0}}, 1'b1};
               settled_q <= ((cur + {{(VW-1){1'b0}}, 1'b1}) == target);
            end else if (cur > target) begin
               upd_q <= 1'b1;
               upd_val_q <= cur - {{(VW-1){1'b0}}, 1'b1};
               settled_q <= ((cur - {{(VW-1){1'b0}}, 1'b1}) == target);
            end else begin
               settled_q <= 1'b1;
            end
         end
      end
   end

endmodule

// >>> core/fcrm_top.v
// Feature control register bank with off, auto, manual and one-shot modes.
//
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/100ps
`include "fcrm_consts.vh"

module fcrm_top #(
   parameter NUM_FEAT = 4,                               // Number of feature registers.
   parameter AW = 8,                                     // Byte address width.
   parameter VW = `FCRM_VALUE_W,                         // Value field width.
   parameter [NUM_FEAT-1:0] PRESENT = {NUM_FEAT{1'b1}},  // Feature implemented.
   parameter [NUM_FEAT-1:0] SUP_OFF = {NUM_FEAT{1'b1}},  // Off state supported.
   parameter [NUM_FEAT-1:0] SUP_AUTO = {NUM_FEAT{1'b1}}, // Auto state supported.
   parameter [NUM_FEAT-1:0] SUP_ONESHOT = {NUM_FEAT{1'b1}} // One-shot supported.
) (
   input wire mclk,                          // Device clock, 50 MHz.
   input wire rst,                           // Synchronous reset, active high.
   input wire [AW-1:0] addr,                 // Register byte address.
   input wire [31:0] wdata,                  // Write data.
   input wire wr,                            // Write strobe, one cycle.
   input wire rd,                            // Read strobe, one cycle.
   output reg [31:0] rdata_q,                // Read data, valid the cycle after rd.
   input wire [NUM_FEAT*VW-1:0] adj_target,  // Per-feature target from the measurement path.
   output wire [NUM_FEAT*VW-1:0] feat_value, // Per-feature value in use, from flops.
   output wire [NUM_FEAT*4-1:0] feat_state   // Per-feature one-hot state, from flops.
);

   // ----------------------------------------------------------------------------
   // State codes
   // ----------------------------------------------------------------------------
   localparam [3:0] ST_OFF = `FCRM_ST_OFF;
   localparam [3:0] ST_AUTO = `FCRM_ST_AUTO;
   localparam [3:0] ST_MANUAL = `FCRM_ST_MANUAL;
   localparam [3:0] ST_ONESHOT = `FCRM_ST_ONESHOT;
   localparam [31:0] ADJ_FULL = `FCRM_ADJ_CYCLES;
   localparam [15:0] ADJ_CYCLES = ADJ_FULL[15:0];

   // ----------------------------------------------------------------------------
   // Written mode bits
   // ----------------------------------------------------------------------------
   // Bit positions come straight from the header macros, which already hold the Verilog indices.
   wire w_en;
   wire w_auto;
   wire w_os;
   wire [VW-1:0] w_val;

   assign w_en = wdata[`FCRM_POS_ENABLE];
   assign w_auto = wdata[`FCRM_POS_AUTO];
   assign w_os = wdata[`FCRM_POS_ONESHOT];
   assign w_val = wdata[`FCRM_POS_VALUE_LO +: VW];

   wire [NUM_FEAT*32-1:0] rd_words;
   wire [NUM_FEAT-1:0] rd_hits;
   wire [NUM_FEAT-1:0] busy;

   // ----------------------------------------------------------------------------
   // Per-feature register and state machine
   // ----------------------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < NUM_FEAT; i = i + 1) begin : g_feat
         localparam [31:0] FOFF = `FCRM_FEAT_BASE + i * `FCRM_FEAT_STRIDE;
         localparam [AW-1:0] FADDR = FOFF[AW-1:0];
         reg [3:0] state_q;
         reg [3:0] state_d;
         reg [VW-1:0] val_q;
         reg [VW-1:0] val_d;
         reg [3:0] req_st;
         wire hit;
         wire upd;
         wire [VW-1:0] upd_val;
         wire settled;
         wire run;

         assign hit = (addr == FADDR);
         assign run = (state_q == ST_AUTO) || (state_q == ST_ONESHOT);

         // Engine only advances the value while the feature adjusts itself.
         fcrm_adjust #(
            .VW(VW),
            .ADJ_CYCLES(ADJ_CYCLES)
         ) u_adj (
            .mclk(mclk),
            .rst(rst),
            .run(run),
            .cur(val_q),
            .target(adj_target[i*VW +: VW]),
            .upd_q(upd),
            .upd_val_q(upd_val),
            .settled_q(settled)
         );

         // Decode the written mode bits; unsupported requests fall back to a built state.
         always @* begin
            req_st = ST_MANUAL;
            if (!w_en && SUP_OFF[i]) begin
               req_st = ST_OFF;
            end else if (w_auto && SUP_AUTO[i]) begin
               req_st = ST_AUTO;
            end else if (w_os && SUP_ONESHOT[i]) begin
               req_st = ST_ONESHOT;
            end
         end

         // Next state: a register write wins over the self-clear of one-shot,
         // so a one-shot request arriving as the last one finishes is kept.
         always @* begin
            state_d = state_q;
            case (state_q)
               ST_OFF: begin
                  state_d = ST_OFF;
               end
               ST_AUTO: begin
                  state_d = ST_AUTO;
               end
               ST_MANUAL: begin
                  state_d = ST_MANUAL;
               end
               ST_ONESHOT: begin
                  if (settled) begin
                     state_d = ST_MANUAL;
                  end
               end
               default: begin
                  state_d = ST_OFF;
               end
            endcase
            if (wr && hit && PRESENT[i]) begin
               state_d = req_st;
            end
         end

         // Next value: software only in manual, the engine only in auto or one-shot.
         // A write that also leaves manual takes the mode only, so no value slips out with it.
         always @* begin
            val_d = val_q;
            case (state_q)
               ST_MANUAL: begin
                  if (wr && hit && PRESENT[i] && (req_st == ST_MANUAL)) begin
                     val_d = w_val;
                  end
               end
               ST_AUTO, ST_ONESHOT: begin
                  if (upd) begin
                     val_d = upd_val;
                  end
               end
               ST_OFF: begin
                  val_d = val_q;
               end
               default: begin
                  val_d = val_q;
               end
            endcase
         end

         // An absent feature is held off and at its reset value.
         always @(posedge mclk) begin
            if (rst || !PRESENT[i]) begin
               state_q <= `FCRM_RST_STATE;
               val_q <= `FCRM_RST_VALUE;
            end else begin
               state_q <= state_d;
               val_q <= val_d;
            end
         end

         // Read word: mode bits mirror the state, so one-shot reads back clear once done.
         assign rd_words[i*32 +: 32] = PRESENT[i] ?
            ({32{1'b0}} |
             (32'h00000001 << `FCRM_POS_PRESENCE) |
             ({31'h00000000, (state_q != ST_OFF)} << `FCRM_POS_ENABLE) |
             ({31'h00000000, (state_q == ST_AUTO)} << `FCRM_POS_AUTO) |
             ({31'h00000000, (state_q == ST_ONESHOT)} << `FCRM_POS_ONESHOT) |
             ({{(32-VW){1'b0}}, val_q} << `FCRM_POS_VALUE_LO)) :
            32'h00000000;
         assign rd_hits[i] = hit;
         assign busy[i] = run;
         assign feat_value[i*VW +: VW] = val_q;
         assign feat_state[i*4 +: 4] = state_q;
      end
   endgenerate

   // ----------------------------------------------------------------------------
   // Read multiplexer
   // ----------------------------------------------------------------------------
   // Unmapped or unaligned addresses read as zero; writes to them are dropped.
   reg [31:0] rd_mux;
   integer k;

   always @* begin
      rd_mux = 32'h00000000;
      for (k = 0; k < NUM_FEAT; k = k + 1) begin
         if (rd_hits[k]) begin
            rd_mux = rd_words[k*32 +: 32];
         end
      end
      if (addr == `FCRM_STAT_ADDR) begin
         rd_mux = {{(32-NUM_FEAT){1'b0}}, busy};
      end
   end

   // Read data stand for exactly one cycle after the strobe and read zero otherwise.
   always @(posedge mclk) begin
      if (rst) begin
         rdata_q <= 32'h00000000;
      end else if (rd) begin
         rdata_q <= rd_mux;
      end else begin
         rdata_q <= 32'h00000000;
      end
   end

endmodule

// >>> tb/fcrm_top_monitor.sv
// Concurrent checks on feature 0 of the feature control register bank.
`timescale 1ns/100ps
module fcrm_monitor #(
   parameter NUM_FEAT = 4, // Number of features.
   parameter AW = 8, // Address width.
   parameter VW = 12 // Value width.
) (
   input wire mclk, // Device clock.
   input wire rst, // Synchronous reset.
   input wire [AW-1:0] addr, // Byte address.
   input wire [31:0] wdata, // Write data.
   input wire wr, // Write strobe.
   input wire rd, // Read strobe.
   input wire [31:0] rdata_q, // Read data.
   input wire [NUM_FEAT*VW-1:0] adj_target, // Adjust targets.
   input wire [NUM_FEAT*VW-1:0] feat_value, // Values in use.
   input wire [NUM_FEAT*4-1:0] feat_state // One-hot states.
);
   // ----------------------------------------------------------------------
   // Feature 0 taps
   // ----------------------------------------------------------------------
   // Only feature 0 is watched, since every feature shares the same logic.
   wire [VW-1:0] v0 = feat_value[VW-1:0];
   wire [VW-1:0] t0 = adj_target[VW-1:0];
   wire [3:0] s0 = feat_state[3:0];
   wire wr0 = wr && (addr == {AW{1'b0}});
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   sequence adjusting_s;
      (s0[1] || s0[3]) && v0 != t0;
   endsequence
   sequence moved_s;
      $changed(v0) || v0 == t0 || !(s0[1] || s0[3]);
   endsequence
   state_onehot_a: assert property ($onehot(s0))
      else $error("feature state is not one-hot");
   read_idle_a: assert property (!$past(rd) |-> rdata_q == 32'h00000000)
      else $error("read data outside the answer cycle");
   read_word_a: assert property (rd && addr == {AW{1'b0}} |=> rdata_q[31] && rdata_q[VW-1:0] == $past(v0)
      && rdata_q[25] == !$past(s0[0]) && rdata_q[26] == $past(s0[3]))
      else $error("read word does not show state and value");
   off_frozen_a: assert property (s0[0] && $past(s0[0]) |-> $stable(v0))
      else $error("value moved while off");
   manual_write_a: assert property (wr0 && s0[2] && wdata[26:24] == 3'b010 |=> v0 == $past(wdata[VW-1:0]))
      else $error("manual value write not taken");
   off_write_a: assert property (wr0 && s0[0] |=> $stable(v0))
      else $error("value write taken while off");
   auto_step_a: assert property (adjusting_s |-> ##[1:60] moved_s)
      else $error("adjustment made no step");
   step_size_a: assert property ($changed(v0) && !$past(wr) |->
      ($past(v0) < $past(t0) && v0 == $past(v0) + 1'b1) || ($past(v0) > $past(t0) && v0 == $past(v0) - 1'b1))
      else $error("adjust step is not one toward target");
   oneshot_done_a: assert property (s0[3] && v0 == t0 && !wr |-> ##[1:60] s0[2])
      else $error("one-shot did not return to manual");
endmodule
bind fcrm_top fcrm_monitor #(.NUM_FEAT(NUM_FEAT), .AW(AW), .VW(VW)) i_mon (.mclk(mclk), .rst(rst), .addr(addr),
   .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q), .adj_target(adj_target), .feat_value(feat_value),
   .feat_state(feat_state));

// >>> tb/fcrm_top_bench.sv
// Self-checking bench for the feature control register bank.
`timescale 1ns/100ps
module fcrm_top_bench;
   reg mclk = 1'b0;
   reg rst = 1'b1;
   reg [7:0] addr = 8'h00;
   reg [31:0] wdata = 32'h00000000;
   reg wr = 1'b0;
   reg rd = 1'b0;
   reg [47:0] adj_target = 48'h000000000000;
   wire [31:0] rdata_q;
   wire [47:0] feat_value;
   wire [15:0] feat_state;
   integer failures = 0;
   integer samples_checked = 0;
   integer i;
   integer n;
   reg [31:0] got;
   reg [47:0] rows [0:7];
   fcrm_top i_dut (.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q),
      .adj_target(adj_target), .feat_value(feat_value), .feat_state(feat_state));
   // ----------------------------------------------------------------------
   // Clock, tasks and watchdog
   // ----------------------------------------------------------------------
   // Half period of the 50 MHz clock.
   always #10 mclk = ~mclk;
   task check(input [31:0] g, input [31:0] e);
      begin
         samples_checked = samples_checked + 1;
         if (g !== e) begin
            failures = failures + 1;
            $display("Error at %0t: got %h expected %h", $time, g, e);
         end
      end
   endtask
   // Strobes drop one edge later, so back-to-back calls never collide.
   task wr_reg(input [7:0] a, input [31:0] d);
      begin
         @(posedge mclk);
         wr <= 1'b1;
         addr <= a;
         wdata <= d;
         @(posedge mclk);
         wr <= 1'b0;
         #1;
      end
   endtask
   task rd_reg(input [7:0] a);
      begin
         @(posedge mclk);
         rd <= 1'b1;
         addr <= a;
         @(posedge mclk);
         rd <= 1'b0;
         #1;
         got = rdata_q;
      end
   endtask
   task final_report;
      begin
         $display("Checks made %0d, mismatches %0d", samples_checked, failures);
         if (failures == 0 && samples_checked > 0) begin
            $display("verification passed");
         end else begin
            $display("verification failed");
         end
         $finish;
      end
   endtask
   // The whole run needs under a thousand cycles; this allows ample slack.
   initial begin
      #200000;
      failures = failures + 1;
      $display("Error at %0t: watchdog expired", $time);
      final_report;
   end
   // ----------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------
   // Rows hold the write word, then the expected state and value.
   initial begin
      rows[0] = 48'h020001234000;
      rows[1] = 48'h020001234123;
      rows[2] = 48'h000004561123;
      rows[3] = 48'h000004561123;
      rows[4] = 48'h010007891123;
      rows[5] = 48'h02000FFF4123;
      rows[6] = 48'h02000FFF4FFF;
      rows[7] = 48'h020000004000;
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      for (i = 0; i < 4; i = i + 1) begin
         rd_reg(i * 4);
         check(got, 32'h80000000);
      end
      check(feat_state, 16'h1111);
      rd_reg(8'h40);
      check(got, 32'h00000000);
      $display("Test reset done");
      for (i = 0; i < 8; i = i + 1) begin
         wr_reg(8'h00, rows[i][47:16]);
         check(feat_state[3:0], rows[i][15:12]);
         check(feat_value[11:0], rows[i][11:0]);
         rd_reg(8'h00);
         check(got & 32'h86000FFF, {20'h80000, rows[i][11:0]} | (rows[i][14] ? 32'h02000000 : 32'h0));
      end
      wr_reg(8'h04, 32'h02000000);
      wr_reg(8'h04, 32'h02000ABC);
      wr_reg(8'h06, 32'h02000555);
      check(feat_state, 16'h1144);
      check(feat_value[23:0], 24'hABC000);
      rd_reg(8'h04);
      check(got, 32'h82000ABC);
      $display("Test mode table done");
      @(posedge mclk);
      adj_target[11:0] <= 12'h005;
      wr_reg(8'h00, 32'h03000000);
      check(feat_state[3:0], 4'h2);
      rd_reg(8'h80);
      check(got & 32'h00000001, 32'h00000001);
      n = 0;
      while (feat_value[11:0] !== 12'h005 && n < 600) begin
         @(posedge mclk);
         #1;
         n = n + 1;
      end
      check(feat_value[11:0], 12'h005);
      wr_reg(8'h00, 32'h03000ABC);
      check(feat_value[11:0], 12'h005);
      wr_reg(8'h00, 32'h02000000);
      check({feat_state[3:0], feat_value[11:0]}, 16'h4005);
      $display("Test auto done");
      @(posedge mclk);
      adj_target[11:0] <= 12'h002;
      wr_reg(8'h00, 32'h06000005);
      check(feat_state[3:0], 4'h8);
      n = 0;
      while (feat_state[3:0] !== 4'h4 && n < 600) begin
         @(posedge mclk);
         #1;
         n = n + 1;
      end
      #1;
      rd_reg(8'h00);
      check(got, 32'h82000002);
      $display("Test one-shot done");
      // One-shot started already at target must still clear itself; the loop below waits up to 600 cycles for it.
      wr_reg(8'h00, 32'h06000000);
      check(feat_state[3:0], 4'h8);
      n = 0;
      while (feat_state[3:0] !== 4'h4 && n < 600) begin
         @(posedge mclk);
         #1;
         n = n + 1;
      end
      check({feat_state[3:0], feat_value[11:0]}, 16'h4002);
      $display("Test one-shot at target done");
      @(posedge mclk);
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      #1;
      check(feat_state, 16'h1111);
      check(feat_value[31:0], 32'h00000000);
      check(feat_value[47:32], 16'h0000);
      rd_reg(8'h04);
      check(got, 32'h80000000);
      $display("Test mid-run reset done");
      final_report;
   end
endmodule
